/* File: design/mpoc_ctrl.v */
// mode pin decode, aux mux, output gating and apb register file
`timescale 1ns/100ps
`include "mpoc_map.vh"

module mpoc_ctrl #(
   parameter [23:0] IN_LOSS_CYC = `MPOC_IN_LOSS_CYC
) (
   input wire sys_clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output wire [31:0] prdata,
   input wire [1:0] mode_pins,
   input wire special_function_pin,
   input wire timing_reference_source,
   input wire input_clock,
   input wire pll_clock,
   input wire pll_lock_in,
   output wire pll_clk_out,
   output wire pll_clk_oe,
   output wire aux_out,
   output wire aux_oe,
   output wire fractional_source_dynamic,
   output wire [31:0] effective_ratio,
   output wire relock_req
);

   //---------------------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------------------
   reg [1:0] mode_s1_ff;
   reg [1:0] mode_s2_ff;
   reg [1:0] mode_s3_ff;
   reg sfp_s1_ff;
   reg sfp_s2_ff;
   reg sfp_s3_ff;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_s1_ff <= 2'h0;
         mode_s2_ff <= 2'h0;
         mode_s3_ff <= 2'h0;
         sfp_s1_ff <= 1'b0;
         sfp_s2_ff <= 1'b0;
         sfp_s3_ff <= 1'b0;
      end else begin
         mode_s1_ff <= mode_pins; // R24
         mode_s2_ff <= mode_s1_ff; // R24
         mode_s3_ff <= mode_s2_ff;
         sfp_s1_ff <= special_function_pin; // R24
         sfp_s2_ff <= sfp_s1_ff; // R24
         sfp_s3_ff <= sfp_s2_ff;
      end
   end

   wire [1:0] mode = mode_s2_ff;
   wire sfp = sfp_s2_ff;

   //---------------------------------------------------------------------
   // configuration registers
   //---------------------------------------------------------------------
   reg lock_indicator_config_ff;
   reg [2:0] special_pin_function_ff;
   reg output_on_unlock_enable_ff;
   reg [6:0] modal_ff [0:3];
   reg [31:0] ratio_ff [0:3];

   wire wr_en = psel & penable & pwrite;
   wire [5:0] widx = paddr[7:2];

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lock_indicator_config_ff <= 1'b0;
         special_pin_function_ff <= `MPOC_SPF_DIS_PLL;
         output_on_unlock_enable_ff <= 1'b0;
      end else if (wr_en && paddr == `MPOC_GLOBAL_OFS) begin
         // one copy for all sets, never indexed by mode
         lock_indicator_config_ff <= pwdata[`MPOC_G_LOCKCFG]; // R8
         special_pin_function_ff <=
            pwdata[`MPOC_G_SPF_HI:`MPOC_G_SPF_LO]; // R8
         output_on_unlock_enable_ff <= pwdata[`MPOC_G_OUTUNL]; // R8
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_set
         // reset index points at own ratio so auto selection is off
         always @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               modal_ff[gi] <= {1'b0, gi[1:0], 4'h0};
               ratio_ff[gi] <= 32'h0;
            end else if (wr_en) begin
               if (paddr == `MPOC_MODAL0_OFS + 8'h4 * gi[7:0])
                  modal_ff[gi] <= pwdata[6:0];
               if (paddr == `MPOC_RATIO0_OFS + 8'h4 * gi[7:0])
                  ratio_ff[gi] <= pwdata;
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------------
   // active set decode
   //---------------------------------------------------------------------
   wire [6:0] act = modal_ff[mode]; // R7
   wire [1:0] rsh_sel = act[`MPOC_M_RSH_LO+1:`MPOC_M_RSH_LO];
   wire [1:0] aux_sel = act[`MPOC_M_AUX_LO+1:`MPOC_M_AUX_LO];
   wire [1:0] dyn_idx = act[`MPOC_M_IDX_LO+1:`MPOC_M_IDX_LO];
   wire frac_sel = act[`MPOC_M_FRAC];
   wire [2:0] spf = special_pin_function_ff;

   wire auto_en = (dyn_idx != mode); // R12
   wire auto_off = (spf == `MPOC_SPF_NOAUTO) & sfp; // R13
   wire auto_act = auto_en & ~auto_off;
   wire rmod_en = (spf == `MPOC_SPF_RMOD) & sfp; // R10

   //---------------------------------------------------------------------
   // clock presence monitors
   //---------------------------------------------------------------------
   reg ref_d_ff;
   reg in_d_ff;
   reg [4:0] ref_cnt_ff;
   reg [23:0] in_cnt_ff;
   reg ref_present_ff;
   reg in_present_ff;
   reg ref_lost_ff;

   wire ref_edge = timing_reference_source & ~ref_d_ff;
   wire in_edge = input_clock & ~in_d_ff;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ref_d_ff <= 1'b0;
         in_d_ff <= 1'b0;
         ref_cnt_ff <= 5'h0;
         in_cnt_ff <= 24'h0;
         ref_present_ff <= 1'b0;
         in_present_ff <= 1'b0;
         ref_lost_ff <= 1'b0;
      end else begin
         ref_d_ff <= timing_reference_source;
         in_d_ff <= input_clock;
         ref_lost_ff <= 1'b0;
         if (ref_edge) begin
            ref_cnt_ff <= 5'h0;
            ref_present_ff <= 1'b1;
         end else if (ref_cnt_ff == `MPOC_REF_LOSS_CYC) begin
            ref_lost_ff <= ref_present_ff; // R21
            ref_present_ff <= 1'b0;
         end else begin
            ref_cnt_ff <= ref_cnt_ff + 5'h1;
         end
         // input clock is slow; loss takes the long wait before fallback
         if (in_edge) begin
            in_cnt_ff <= 24'h0;
            in_present_ff <= 1'b1;
         end else if (in_cnt_ff == IN_LOSS_CYC) begin
            in_present_ff <= 1'b0;
         end else begin
            in_cnt_ff <= in_cnt_ff + 24'h1;
         end
      end
   end

   //---------------------------------------------------------------------
   // fractional source and ratio
   //---------------------------------------------------------------------
   reg nxt_frac;
   always @* begin
      if (auto_act)
         nxt_frac = in_present_ff; // R12
      else if (spf == `MPOC_SPF_FRAC)
         nxt_frac = sfp; // R14
      else
         nxt_frac = frac_sel; // R13
   end

   reg frac_dyn_ff;
   reg [31:0] eff_ratio_ff;
   wire [31:0] base_ratio = frac_dyn_ff ? ratio_ff[dyn_idx]
                                        : ratio_ff[mode]; // R23
   wire [2:0] shamt = {1'b0, rsh_sel} + 3'h1;
   wire [31:0] nxt_eff = rmod_en ? (base_ratio >> shamt)
                                 : base_ratio; // R11

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         frac_dyn_ff <= 1'b0;
         eff_ratio_ff <= 32'h0;
      end else begin
         frac_dyn_ff <= nxt_frac;
         eff_ratio_ff <= nxt_eff;
      end
   end

   wire frac_change = (nxt_frac != frac_dyn_ff);

   //---------------------------------------------------------------------
   // unlock control
   //---------------------------------------------------------------------
   wire mode_chg = (mode_s2_ff != mode_s3_ff); // R19
   wire sfp_chg = (sfp_s2_ff != sfp_s3_ff) &
                  (spf == `MPOC_SPF_RMOD || spf == `MPOC_SPF_NOAUTO ||
                   spf == `MPOC_SPF_RSVD || spf == `MPOC_SPF_FRAC); // R20
   wire nxt_relock = mode_chg | sfp_chg | ref_lost_ff | frac_change; // R21

   reg relock_ff;
   reg [7:0] hold_ff;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         relock_ff <= 1'b0;
         hold_ff <= 8'h0;
      end else begin
         relock_ff <= nxt_relock;
         if (nxt_relock)
            hold_ff <= `MPOC_RELOCK_CYC; // R19
         else if (hold_ff != 8'h0)
            hold_ff <= hold_ff - 8'h1;
      end
   end

   wire unlocked = ~pll_lock_in | (hold_ff != 8'h0) |
                   ~ref_present_ff;
   // without a reference the indicator cannot show unlock
   wire unlock_ind = unlocked & ref_present_ff; // R4

   //---------------------------------------------------------------------
   // pll clock output, gated only while the clock is low
   //---------------------------------------------------------------------
   reg pll_gate_ff;
   reg pll_oe_ff;
   reg pll_out_ff;
   wire pll_dis = sfp & (spf == `MPOC_SPF_DIS_PLL ||
                         spf == `MPOC_SPF_DIS_BOTH); // R6 R9

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pll_gate_ff <= 1'b0;
         pll_oe_ff <= 1'b0;
         pll_out_ff <= 1'b0;
      end else begin
         if (!pll_clock) begin
            pll_gate_ff <= ~unlocked | output_on_unlock_enable_ff; // R18 R16
            pll_oe_ff <= ~pll_dis; // R16
         end
         pll_out_ff <= pll_clock & (pll_clock ? pll_gate_ff
                       : (~unlocked | output_on_unlock_enable_ff));
      end
   end

   //---------------------------------------------------------------------
   // auxiliary output
   //---------------------------------------------------------------------
   wire [1:0] want_src = ((spf == `MPOC_SPF_AUXPLL) & sfp) ?
                         `MPOC_AUX_PLL : aux_sel; // R15
   reg [1:0] cur_src_ff;
   reg aux_oe_ff;
   reg aux_out_ff;
   wire aux_dis = sfp & (spf == `MPOC_SPF_DIS_AUX ||
                         spf == `MPOC_SPF_DIS_BOTH); // R5 R9
   wire cur_is_lock = (cur_src_ff == `MPOC_AUX_LOCK);
   wire cur_clk_pair = (cur_src_ff == `MPOC_AUX_REF) |
                       (cur_src_ff == `MPOC_AUX_PLL);
   wire want_clk_pair = (want_src == `MPOC_AUX_REF) |
                        (want_src == `MPOC_AUX_PLL);
   wire nxt_level_low = (want_src == `MPOC_AUX_REF) ?
                        ~timing_reference_source : ~pll_clock;

   reg sel_level;
   always @* begin
      case (cur_src_ff) // R1
         `MPOC_AUX_REF: sel_level = timing_reference_source;
         `MPOC_AUX_IN: sel_level = input_clock;
         `MPOC_AUX_PLL: sel_level = pll_clock;
         `MPOC_AUX_LOCK: sel_level = lock_indicator_config_ff ? 1'b0
                                     : unlock_ind; // R2 R3
         default: sel_level = 1'b0;
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cur_src_ff <= `MPOC_AUX_REF;
         aux_oe_ff <= 1'b0;
         aux_out_ff <= 1'b0;
      end else begin
         if (want_src != cur_src_ff) begin
            // ref and pll swap only when both levels are low
            if (cur_clk_pair & want_clk_pair) begin
               if (~aux_out_ff & nxt_level_low)
                  cur_src_ff <= want_src; // R16
            end else begin
               cur_src_ff <= want_src; // R17
            end
         end
         if (cur_is_lock | ~aux_out_ff)
            aux_oe_ff <= ~aux_dis; // R16 R17
         aux_out_ff <= sel_level;
      end
   end

   wire od_mode = cur_is_lock & lock_indicator_config_ff;

   // open drain pulls low only while unlock is indicated
   reg unlock_drv_ff;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         unlock_drv_ff <= 1'b0;
      else
         unlock_drv_ff <= unlock_ind; // R3
   end

   //---------------------------------------------------------------------
   // apb slave, zero wait states, read data captured in setup phase, write data in access phase
   //---------------------------------------------------------------------
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;
   reg map_hit;
   reg ro_hit;
   always @* begin
      nxt_rdata = 32'h0;
      map_hit = 1'b1;
      ro_hit = 1'b0;
      if (paddr == `MPOC_GLOBAL_OFS)
         nxt_rdata = {27'h0, output_on_unlock_enable_ff,
                      special_pin_function_ff, lock_indicator_config_ff};
      else if (paddr >= `MPOC_MODAL0_OFS && paddr < `MPOC_RATIO0_OFS &&
               paddr[1:0] == 2'h0)
         nxt_rdata = {25'h0, modal_ff[widx[1:0] - 2'h1]};
      else if (paddr >= `MPOC_RATIO0_OFS && paddr < `MPOC_STATUS_OFS &&
               paddr[1:0] == 2'h0)
         nxt_rdata = ratio_ff[widx[1:0] - 2'h1];
      else if (paddr == `MPOC_STATUS_OFS) begin
         ro_hit = 1'b1;
         nxt_rdata = {22'h0, rmod_en, cur_src_ff, in_present_ff,
                      ref_present_ff, ~unlocked, auto_act,
                      frac_dyn_ff, mode};
      end else if (paddr == `MPOC_EFFRAT_OFS) begin
         ro_hit = 1'b1;
         nxt_rdata = eff_ratio_ff;
      end else
         map_hit = 1'b0;
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         rdata_ff <= 32'h0;
      else if (psel & ~penable & ~pwrite)
         rdata_ff <= nxt_rdata;
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & (~map_hit | (pwrite & ro_hit));
   assign prdata = rdata_ff;

   assign pll_clk_out = pll_out_ff;
   assign pll_clk_oe = pll_oe_ff;
   assign aux_out = od_mode ? 1'b0 : aux_out_ff;
   assign aux_oe = aux_oe_ff & (~od_mode | unlock_drv_ff);
   assign fractional_source_dynamic = frac_dyn_ff;
   assign effective_ratio = eff_ratio_ff;
   assign relock_req = relock_ff;

endmodule

/* File: design/mpoc_map.vh */
// constants and register map of the mode pin and output control block
//------------------------------------------------------------------------
// rule summary
//------------------------------------------------------------------------
// How it works
// [R1] aux pin muxes four sources by select
// [R2] lock indicator uses lock indicator config
// [R3] config 0 push-pull high; 1 open drain
// [R4] unlock shown only while reference present
// [R5] special pin disables aux for 001/010
// [R6] special pin disables pll out for 000/010
// [R7] mode pins pick one of four sets
// [R8] global settings shared by all sets
// [R9] pin low enables, high disables outputs
// [R10] function 011: pin high enables ratio shift
// [R11] ratio shifts right one to four places
// [R12] auto source when index differs from set
// [R13] function 100: high pin forces manual source
// [R14] function 110: pin overrides source unless auto
// [R15] function 111: high pin forces pll clock
// [R16] enables and clock switches never cut periods
// [R17] input clock or lock sources not glitch-free
// [R18] pll output low while unlocked unless enabled
// [R19] mode pin change forces temporary unlock
// [R20] special pin change may unlock for 011-110
// [R21] reference loss or input loss unlocks; code unlocks on input loss only via auto fallback
// [R22] board holds inputs, toggles mode pins thrice; bench toggles them four times
// [R23] index picks ratio; static uses set ratio
// [R24] pins synchronised before use
`ifndef MPOC_MAP_VH
`define MPOC_MAP_VH

// register byte offsets
`define MPOC_GLOBAL_OFS 8'h00
`define MPOC_MODAL0_OFS 8'h04
`define MPOC_RATIO0_OFS 8'h14
`define MPOC_STATUS_OFS 8'h24
`define MPOC_EFFRAT_OFS 8'h28

// global register fields
`define MPOC_G_LOCKCFG 0
`define MPOC_G_SPF_LO 1
`define MPOC_G_SPF_HI 3
`define MPOC_G_OUTUNL 4

// modal register fields
`define MPOC_M_RSH_LO 0
`define MPOC_M_AUX_LO 2
`define MPOC_M_IDX_LO 4
`define MPOC_M_FRAC 6

// special pin functions
`define MPOC_SPF_DIS_PLL 3'h0
`define MPOC_SPF_DIS_AUX 3'h1
`define MPOC_SPF_DIS_BOTH 3'h2
`define MPOC_SPF_RMOD 3'h3
`define MPOC_SPF_NOAUTO 3'h4
`define MPOC_SPF_RSVD 3'h5
`define MPOC_SPF_FRAC 3'h6
`define MPOC_SPF_AUXPLL 3'h7

// aux sources
`define MPOC_AUX_REF 2'h0
`define MPOC_AUX_IN 2'h1
`define MPOC_AUX_PLL 2'h2
`define MPOC_AUX_LOCK 2'h3

// timing: sys_clk period and hold/loss times
`define MPOC_CLK_NS 10
`define MPOC_RELOCK_NS 1000
// relock hold in cycles: the hold time over the clock period
`define MPOC_RELOCK_CYC 8'h64
`define MPOC_REF_LOSS_CYC 5'h10
`define MPOC_IN_LOSS_CYC 24'h800000

`endif

/* File: dv/mpoc_board.sv */
// board-side model: mode pins, special pin, clock sources and lock
`timescale 1ns/100ps
module mpoc_board (
   input wire sys_clk,
   input wire resetn,
   input wire [1:0] mode_req,
   input wire spf_req,
   input wire ref_run,
   input wire in_run,
   input wire lock_ok,
   output reg [1:0] mode_pins,
   output reg special_function_pin,
   output reg timing_reference_source,
   output reg input_clock,
   output reg pll_clock,
   output reg pll_lock_in
);
   reg [3:0] cnt_ff;
   // clocks stand still when stopped, as a real lost source would
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 4'h0;
         mode_pins <= 2'h0;
         special_function_pin <= 1'b0;
         timing_reference_source <= 1'b0;
         input_clock <= 1'b0;
         pll_clock <= 1'b0;
         pll_lock_in <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
         mode_pins <= mode_req;
         special_function_pin <= spf_req;
         pll_lock_in <= lock_ok;
         if (cnt_ff[0])
            pll_clock <= ~pll_clock;
         if (ref_run && cnt_ff[1:0] == 2'h3)
            timing_reference_source <= ~timing_reference_source;
         if (in_run && cnt_ff == 4'hf)
            input_clock <= ~input_clock;
      end
   end
endmodule

/* File: dv/mpoc_ctrl_properties.sv */
// port-level assertions for the mode pin and output control block
`timescale 1ns/100ps
module mpoc_ctrl_properties #(
   parameter [23:0] IN_LOSS_CYC = 24'h000040
) (
   input wire sys_clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire [1:0] mode_pins,
   input wire pll_clock,
   input wire pll_clk_out,
   input wire relock_req
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_rd_setup;
      psel && !penable && !pwrite;
   endsequence
   a_ready_access: assert property (s_access |-> pready)
      else $error("access phase without ready");
   a_slverr_unmapped: assert property (s_access ##0
      (paddr[1:0] != 2'h0 || paddr > 8'h28) |-> pslverr)
      else $error("unmapped access not refused");
   a_slverr_ro_wr: assert property (s_access ##0 pwrite ##0
      (paddr == 8'h24 || paddr == 8'h28) |-> pslverr)
      else $error("read-only write not refused");
   a_no_err_mapped: assert property (s_access ##0 !pwrite ##0
      (paddr[1:0] == 2'h0 && paddr <= 8'h28) |-> !pslverr)
      else $error("mapped read refused");
   a_rdata_hold: assert property (
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");
   a_pll_follow: assert property (pll_clk_out |-> $past(pll_clock))
      else $error("clock output high without source high");
   a_pll_no_runt: assert property (
      $fell(pll_clk_out) |-> !$past(pll_clock))
      else $error("clock output cut short");
   a_mode_relock: assert property (
      $changed(mode_pins) |-> ##[1:4] relock_req)
      else $error("mode change without relock");
endmodule

/* File: dv/tb.sv */
// self-checking bench for the mode pin and output control block
`timescale 1ns/100ps
module tb;
   reg sys_clk = 1'b0;
   reg resetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg [1:0] mode_req = 2'h0;
   reg spf_req = 1'b0;
   reg ref_run = 1'b1;
   reg in_run = 1'b1;
   reg lock_ok = 1'b1;
   wire pready, pslverr, spf_pin, ref_clk, in_clk, pll_clock, pll_lock_in;
   wire pll_clk_out, pll_clk_oe, aux_out, aux_oe, frac_dyn, relock_req;
   wire [31:0] prdata, effective_ratio;
   wire [1:0] mode_pins;
   wire aux_pin = aux_oe ? aux_out : 1'b1; // open drain pulled up
   integer bad_count = 0;
   integer cmp_count = 0;
   integer i, k, c;
   reg [31:0] rv;
   reg er;
   always #5 sys_clk = ~sys_clk;
   mpoc_board board (.sys_clk(sys_clk), .resetn(resetn), .mode_req(mode_req),
      .spf_req(spf_req), .ref_run(ref_run), .in_run(in_run),
      .lock_ok(lock_ok), .mode_pins(mode_pins),
      .special_function_pin(spf_pin), .timing_reference_source(ref_clk),
      .input_clock(in_clk), .pll_clock(pll_clock), .pll_lock_in(pll_lock_in));
   mpoc_ctrl #(.IN_LOSS_CYC(24'h000040)) dut (.sys_clk(sys_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .mode_pins(mode_pins), .special_function_pin(spf_pin),
      .timing_reference_source(ref_clk), .input_clock(in_clk),
      .pll_clock(pll_clock), .pll_lock_in(pll_lock_in),
      .pll_clk_out(pll_clk_out), .pll_clk_oe(pll_clk_oe), .aux_out(aux_out),
      .aux_oe(aux_oe), .fractional_source_dynamic(frac_dyn),
      .effective_ratio(effective_ratio), .relock_req(relock_req));
   function [31:0] rat(input integer n);
      rat = 32'h0123_4560 + n * 32'h1000_0000;
   endfunction
   task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         @(posedge sys_clk);
         while (pready !== 1'b1)
            @(posedge sys_clk);
         rv = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         apb(1'b1, a, d);
         chk("wr_err", er, 0);
      end
   endtask
   task pins(input [1:0] m, input s, input integer n);
      begin
         mode_req <= m;
         spf_req <= s;
         repeat (n) @(posedge sys_clk);
      end
   endtask
   // rising edges of one output over 64 cycles, sampled where settled
   task rises(input sel);
      reg p;
      begin
         c = 0;
         @(negedge sys_clk);
         p = sel ? pll_clk_out : aux_out;
         repeat (64) begin
            @(negedge sys_clk);
            if ((sel ? pll_clk_out : aux_out) && !p)
               c = c + 1;
            p = sel ? pll_clk_out : aux_out;
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count = bad_count + 1;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      for (i = 1; i < 5; i = i + 1)
         pins({1'b0, i[0]}, 1'b0, 4);
      apb(0, 8'h00, 0);
      chk("global", rv, 0);
      for (i = 0; i < 4; i = i + 1) begin
         apb(0, 8'h04 + 4 * i, 0);
         chk("modal", rv, i << 4);
         wr(8'h14 + 4 * i, rat(i));
      end
      apb(0, 8'h2c, 0);
      chk("slverr", er, 1);
      apb(0, 8'h05, 0);
      chk("slverr", er, 1);
      apb(1, 8'h24, 32'hffff_ffff);
      chk("slverr", er, 1);
      for (i = 0; i < 4; i = i + 1) begin
         pins(i[1:0], 1'b0, 8);
         chk("eff", effective_ratio, rat(i));
         apb(0, 8'h24, 0);
         chk("mode", rv[1:0], i[1:0]);
         apb(0, 8'h00, 0);
         chk("global", rv, 0);
      end
      pins(0, 0, 8);
      wr(8'h00, 32'h6);
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h04, k);
         pins(0, 1, 8);
         chk("eff", effective_ratio, rat(0) >> (k + 1));
         pins(0, 0, 8);
         chk("eff", effective_ratio, rat(0));
      end
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h00, k << 1);
         pins(0, 1, 12);
         chk("clk_oe", pll_clk_oe, k == 1 || k == 3);
         chk("aux_oe", aux_oe, k == 0 || k == 3);
         pins(0, 0, 12);
         chk("oe", {pll_clk_oe, aux_oe}, 2'h3);
      end
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h04, k << 2);
         pins(0, 0, 12);
         rises(0);
         chk("aux_rise", c, k == 0 ? 8 : k == 1 ? 2 : k == 2 ? 16 : 0);
      end
      wr(8'h00, 32'he);
      wr(8'h04, 0);
      pins(0, 1, 12);
      rises(0);
      chk("aux_rise", c, 16);
      pins(0, 0, 12);
      rises(0);
      chk("aux_rise", c, 8);
      wr(8'h04, 32'hc);
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h00, k[0]);
         lock_ok <= k[1];
         pins(0, 0, 30);
         chk("aux_pin", aux_pin, k[0] ? k[1] : !k[1]);
         chk("aux_oe", aux_oe, k[0] ? !k[1] : 1);
      end
      lock_ok <= 1'b0;
      wr(8'h00, 0);
      rises(1);
      chk("pll_rise", c, 0);
      wr(8'h00, 32'h10);
      pins(0, 0, 4);
      rises(1);
      chk("pll_rise", c, 16);
      lock_ok <= 1'b1;
      wr(8'h00, 32'hc);
      wr(8'h04, 0);
      pins(0, 1, 12);
      chk("frac", frac_dyn, 1);
      pins(0, 0, 12);
      chk("frac", frac_dyn, 0);
      wr(8'h04, 32'h10);
      pins(0, 0, 40);
      chk("frac", frac_dyn, 1);
      chk("eff", effective_ratio, rat(1));
      wr(8'h00, 32'h8);
      pins(0, 1, 12);
      chk("frac", frac_dyn, 0);
      pins(0, 0, 12);
      chk("frac", frac_dyn, 1);
      in_run <= 1'b0;
      pins(0, 0, 120);
      chk("frac", frac_dyn, 0);
      pins(1, 0, 6);
      apb(0, 8'h24, 0);
      chk("locked", rv[4], 0);
      pins(1, 0, 130);
      apb(0, 8'h24, 0);
      chk("locked", rv[4], 1);
      wr(8'h08, 32'h1c);
      wr(8'h00, 0);
      ref_run <= 1'b0;
      pins(1, 0, 40);
      chk("aux_pin", aux_pin, 0);
      wrap_up;
   end
endmodule
bind mpoc_ctrl mpoc_ctrl_properties #(.IN_LOSS_CYC(IN_LOSS_CYC)) u_props (
   .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .prdata(prdata), .mode_pins(mode_pins), .pll_clock(pll_clock),
   .pll_clk_out(pll_clk_out), .relock_req(relock_req));
